// ### verilog/ddsip_pkg.sv
/*
  constants shared by both ends of the dual dac serial input link.
  assumes a 100 MHz system clock on each end; the link clock is sampled.
*/
// How it works
// - frame select low; shift data on falling edges
// - host never drops select on clock fall
// - sixteenth falling edge applies the command
// - edges after sixteenth ignored until select high
// - host may hold or release select after
// - host keeps select high minimum time between
// - host parks select and data low idle
// - host sends zero as first bit
// - second bit selects the channel
// - two-bit operation field, four operations
// - ten data bits, straight binary, msb first
// - zero code zero volts, ones full scale
// - early select rise discards the whole frame
// - byte hosts send two bytes, select low
// - spi host uses polarity zero, phase one
// - rising-edge hosts invert their clock
// - operation 11 powers down, lead bits pick termination
// - power-down keeps both channel registers
// - reset clears registers, outputs held zero
package ddsip_pkg;
    localparam int FRAME_BITS = 16;             // bits per frame
    localparam int CODE_BITS = 10;              // dac resolution
    localparam int LEAD_POS = 15;               // first bit sent
    localparam int CHAN_POS = 14;               // channel select bit
    localparam int OP_HI_POS = 13;              // operation field high
    localparam int OP_LO_POS = 12;              // operation field low
    localparam int CODE_HI_POS = 11;            // top of dac code
    localparam int CODE_LO_POS = 2;             // bottom of dac code
    localparam logic [1:0] OP_WRITE = 2'h0;     // write, no update
    localparam logic [1:0] OP_WRITE_UPD = 2'h1; // write and update both
    localparam logic [1:0] OP_BOTH_UPD = 2'h2;  // write both and update
    localparam logic [1:0] OP_POWER_DOWN = 2'h3; // power down both
    localparam logic [1:0] TERM_HIZ = 2'h0;     // open outputs
    localparam logic [1:0] TERM_2K5 = 2'h1;     // 2.5 kohm to ground
    localparam logic [1:0] TERM_100K = 2'h2;    // 100 kohm to ground
    localparam int CLK_MHZ = 100;               // system clock rate
    localparam int SYNC_HIGH_NS = 10;           // least select high time
    localparam int SYNC_HIGH_CYC = (SYNC_HIGH_NS * CLK_MHZ + 999) / 1000; // rounded up
    localparam int HALF_PERIOD_CYC = 8;         // host link clock half period minus one
endpackage

// ### verilog/ddsip_if.sv
/*
  three-wire link between host and dac serial port.
  assumes both ends share the bench's system clock domain only loosely.
*/
`timescale 1ns/100ps
`default_nettype none
interface ddsip_if;
    logic sync_n;   // frame select, active low
    logic sclk;     // serial clock
    logic din;      // serial data
    modport host (output sync_n, output sclk, output din);
    modport dev (input sync_n, input sclk, input din);
endinterface
`default_nettype wire

// ### verilog/ddsip_dev.sv
/*
  device end: samples the link, shifts frames, holds both channel registers,
  outputs and power-down state. assumes sclk slower than clk/4.
*/
`timescale 1ns/100ps
`default_nettype none
module ddsip_dev (
    input wire logic clk,                   // system clock
    input wire logic rst_n,                 // sync reset, active low
    ddsip_if.dev link,                      // serial link
    output logic [9:0] code_a,              // first channel code driving output
    output logic [9:0] code_b,              // second channel code driving output
    output logic powered_down,              // both outputs powered down
    output logic [1:0] termination,         // power-down termination
    output logic frame_done                 // pulse when a frame applies
);
    logic [2:0] sync_s, sclk_s, din_s;      // two-stage synchronisers plus history
    logic [15:0] shreg;                     // input shift register
    logic [4:0] nbits;                      // falling edges seen this frame
    logic [9:0] reg_a, reg_b;               // channel registers
    logic fall, active;
    logic [15:0] w;                         // completed frame

    // synchronise pins; only stages 1 and 2 feed logic
    always_ff @(posedge clk) begin
        sync_s <= {sync_s[1:0], link.sync_n};
        sclk_s <= {sclk_s[1:0], link.sclk};
        din_s <= {din_s[1:0], link.din};
    end

    assign fall = sclk_s[2] & ~sclk_s[1];
    assign active = ~sync_s[1] & (nbits < 5'(ddsip_pkg::FRAME_BITS));
    assign w = {shreg[14:0], din_s[1]};

    // shifting and bit count
    always_ff @(posedge clk) begin
        if (!rst_n || sync_s[1]) begin
            nbits <= 5'h00;                 // high select aborts partial frame
            shreg <= 16'h0000;
        end else if (active && fall) begin
            shreg <= w;                     // msb first
            nbits <= nbits + 5'h01;
        end
    end

    // command execution on the sixteenth edge
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            reg_a <= 10'h000;
            reg_b <= 10'h000;
            code_a <= 10'h000;
            code_b <= 10'h000;
            powered_down <= 1'b0;
            termination <= ddsip_pkg::TERM_HIZ;
            frame_done <= 1'b0;
        end else begin
            frame_done <= 1'b0;
            if (active && fall && nbits == 5'(ddsip_pkg::FRAME_BITS - 1)) begin
                frame_done <= 1'b1;
                case (w[ddsip_pkg::OP_HI_POS:ddsip_pkg::OP_LO_POS])
                    ddsip_pkg::OP_WRITE, ddsip_pkg::OP_WRITE_UPD: begin
                        // channel select and top ten code bits
                        if (w[ddsip_pkg::CHAN_POS]) begin
                            reg_b <= w[ddsip_pkg::CODE_HI_POS:ddsip_pkg::CODE_LO_POS];
                        end else begin
                            reg_a <= w[ddsip_pkg::CODE_HI_POS:ddsip_pkg::CODE_LO_POS];
                        end
                        if (w[ddsip_pkg::OP_LO_POS]) begin
                            // update both; the new value goes straight through
                            code_a <= w[ddsip_pkg::CHAN_POS] ? reg_a
                                : w[ddsip_pkg::CODE_HI_POS:ddsip_pkg::CODE_LO_POS];
                            code_b <= w[ddsip_pkg::CHAN_POS]
                                ? w[ddsip_pkg::CODE_HI_POS:ddsip_pkg::CODE_LO_POS] : reg_b;
                            powered_down <= 1'b0; // wake keeps old registers
                        end
                    end
                    ddsip_pkg::OP_BOTH_UPD: begin
                        reg_a <= w[ddsip_pkg::CODE_HI_POS:ddsip_pkg::CODE_LO_POS];
                        reg_b <= w[ddsip_pkg::CODE_HI_POS:ddsip_pkg::CODE_LO_POS];
                        code_a <= w[ddsip_pkg::CODE_HI_POS:ddsip_pkg::CODE_LO_POS];
                        code_b <= w[ddsip_pkg::CODE_HI_POS:ddsip_pkg::CODE_LO_POS];
                        powered_down <= 1'b0;
                    end
                    default: begin
                        // registers untouched while down
                        powered_down <= 1'b1;
                        termination <= w[ddsip_pkg::LEAD_POS:ddsip_pkg::CHAN_POS]
                            == 2'h3 ? ddsip_pkg::TERM_HIZ
                            : w[ddsip_pkg::LEAD_POS:ddsip_pkg::CHAN_POS];
                    end
                endcase
            end
        end
    end
    // code 0 is 0 V, code 3FF is full scale minus one lsb downstream
endmodule
`default_nettype wire

// ### verilog/ddsip_host.sv
/*
  host end: sends one 16-bit frame per request, msb first, data stable at
  falling sclk edges. assumes the request is held until ready.
*/
`timescale 1ns/100ps
`default_nettype none
module ddsip_host #(
    parameter int HALF = ddsip_pkg::HALF_PERIOD_CYC   // sclk half period minus one, cycles
) (
    input wire logic clk,                   // system clock
    input wire logic rst_n,                 // sync reset, active low
    ddsip_if.host link,                     // serial link
    input wire logic req,                   // send a frame
    input wire logic [15:0] frame,          // frame to send
    input wire logic abort,                 // end frame early (test use)
    output logic ready                      // idle, may take req
);
    typedef enum logic [1:0] {IDLE = 2'b00, SETUP = 2'b01, SHIFT = 2'b10, GAP = 2'b11} ddsip_st_e;
    ddsip_st_e st;                          // sequencer state
    logic [15:0] sh;                        // outgoing bits
    logic [4:0] left;                       // falling edges remaining
    logic [7:0] cnt;                        // half period timer
    logic sclk_r, sync_r, din_r;

    assign link.sclk = sclk_r;
    assign link.sync_n = sync_r;
    assign link.din = din_r;

    // one sequencer: data launched on rising, sampled on falling
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st <= IDLE;
            sclk_r <= 1'b0;
            sync_r <= 1'b0;                 // parked low
            din_r <= 1'b0;
            ready <= 1'b0;
            sh <= 16'h0000;
            left <= 5'h00;
            cnt <= 8'h00;
        end else begin
            case (st)
                IDLE: begin
                    ready <= 1'b1;
                    if (req && ready) begin
                        ready <= 1'b0;
                        sync_r <= 1'b1;     // high first for minimum time
                        sh <= {1'b0, frame[14:0]}; // lead bit forced zero
                        cnt <= 8'(HALF);
                        st <= SETUP;
                    end
                end
                SETUP: begin
                    if (cnt == 8'h00) begin
                        // select falls with sclk high, away from a fall
                        sync_r <= 1'b0;
                        sclk_r <= 1'b1;
                        din_r <= sh[15];
                        sh <= {sh[14:0], 1'b0};
                        left <= 5'(ddsip_pkg::FRAME_BITS);
                        cnt <= 8'(HALF);
                        st <= SHIFT;
                    end else begin
                        cnt <= cnt - 8'h01;
                    end
                end
                SHIFT: begin
                    if (abort) begin
                        sync_r <= 1'b1;     // early rise discards frame
                        sclk_r <= 1'b0;
                        cnt <= 8'(HALF);    // full gap, else select may stay high one cycle
                        st <= GAP;
                    end else if (cnt == 8'h00) begin
                        cnt <= 8'(HALF);
                        sclk_r <= ~sclk_r;
                        if (sclk_r) begin
                            left <= left - 5'h01; // one continuous frame
                        end else if (left == 5'h00) begin
                            sclk_r <= 1'b0;
                            sync_r <= 1'b1; // release after sixteenth
                            st <= GAP;
                        end else begin
                            din_r <= sh[15]; // msb first
                            sh <= {sh[14:0], 1'b0};
                        end
                    end else begin
                        cnt <= cnt - 8'h01;
                    end
                end
                default: begin
                    if (cnt == 8'h00) begin
                        sync_r <= 1'b0;     // park low again
                        din_r <= 1'b0;
                        st <= IDLE;
                    end else begin
                        cnt <= cnt - 8'h01;
                    end
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// ### dv/ddsip_monitor.sv
/*
  link and output checks for the dual dac serial port.
  assumes both ends share clk and the synchronous active-low rst_n.
*/
`timescale 1ns/100ps
`default_nettype none
module ddsip_monitor (
    input wire logic clk, // system clock
    input wire logic rst_n, // sync reset, active low
    input wire logic sync_n, // frame select
    input wire logic sclk, // serial clock
    input wire logic din, // serial data
    input wire logic [9:0] code_a, // first output code
    input wire logic [9:0] code_b, // second output code
    input wire logic powered_down, // outputs down
    input wire logic [1:0] termination, // down termination
    input wire logic frame_done // apply pulse
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // clock parked low whenever select is released
    property p_park; $rose(sync_n) |-> !sclk; endproperty
    a_park: assert property (p_park) else $error("sclk high at select rise");
    // select never drops together with a clock fall
    property p_nosim; $fell(sync_n) |-> !$fell(sclk); endproperty
    a_nosim: assert property (p_nosim) else $error("select fell with sclk");
    // select high for at least two sampled cycles
    property p_gap; $rose(sync_n) |=> sync_n; endproperty
    a_gap: assert property (p_gap) else $error("select high too short");
    // first bit is zero as the frame opens
    property p_lead; $fell(sync_n) |-> !din; endproperty
    a_lead: assert property (p_lead) else $error("lead bit not zero");
    // data steady across each falling clock edge
    property p_din; $fell(sclk) |-> $stable(din); endproperty
    a_din: assert property (p_din) else $error("din moved at sclk fall");
    // apply strobe lasts a single cycle
    property p_pulse; frame_done |=> !frame_done; endproperty
    a_pulse: assert property (p_pulse) else $error("frame_done too long");
    // codes and power state only move with a completed frame
    property p_apply;
        ($changed(code_a) || $changed(code_b) || $changed(powered_down)) |-> frame_done;
    endproperty
    a_apply: assert property (p_apply) else $error("output moved without frame");
    // leaving reset shows zero codes, awake
    property p_por; $rose(rst_n) |-> code_a == 10'h000 && code_b == 10'h000 && !powered_down;
    endproperty
    a_por: assert property (p_por) else $error("reset state wrong");
    // the folded termination code never shows
    property p_term; powered_down |-> termination != 2'h3; endproperty
    a_term: assert property (p_term) else $error("bad termination");
endmodule
`default_nettype wire

// ### dv/dual_dac_serial_input_port_test.sv
/*
  testbench: host end drives dev end over the link; a model predicts outputs.
  assumes the host forces the lead bit to zero.
*/
`timescale 1ns/100ps
`default_nettype none
module dual_dac_serial_input_port_test;
    logic clk = 1'b0; // system clock
    logic rst_n = 1'b0; // reset, active low
    logic req = 1'b0; // frame request
    logic [15:0] frame = 16'h0000; // frame to send
    logic abort = 1'b0; // early select rise
    logic ready, powered_down, frame_done; // design outputs
    logic [9:0] code_a, code_b, done_cnt; // codes and apply count
    logic [1:0] termination; // termination
    logic [9:0] reg_a, reg_b, exp_a, exp_b, exp_done; // model state
    logic exp_pd; // model power state
    logic [1:0] exp_term; // model termination
    logic [15:0] corners [8] = '{16'h5FFF, 16'h0800, 16'h7000, 16'h0004, 16'h3000,
        16'h2FFC, 16'h9123, 16'h4C00};
    int num_errors = 0; // mismatches
    int checks = 0; // comparisons
    ddsip_if ddsip_if_inst ();
    ddsip_host #(.HALF(3)) ddsip_host_inst (.clk(clk), .rst_n(rst_n),
        .link(ddsip_if_inst.host), .req(req), .frame(frame), .abort(abort), .ready(ready));
    ddsip_dev ddsip_dev_inst (.clk(clk), .rst_n(rst_n), .link(ddsip_if_inst.dev),
        .code_a(code_a), .code_b(code_b), .powered_down(powered_down),
        .termination(termination), .frame_done(frame_done));
    ddsip_monitor ddsip_monitor_inst (.clk(clk), .rst_n(rst_n), .sync_n(ddsip_if_inst.sync_n),
        .sclk(ddsip_if_inst.sclk), .din(ddsip_if_inst.din), .code_a(code_a), .code_b(code_b),
        .powered_down(powered_down), .termination(termination), .frame_done(frame_done));
    // free-running system clock
    initial begin
        forever #5 clk = ~clk;
    end
    // count apply pulses; a skipped or doubled pulse shows here
    always @(posedge clk) begin
        if (!rst_n) done_cnt <= 10'h000;
        else if (frame_done === 1'b1) done_cnt <= done_cnt + 10'h001;
    end
    task automatic wrap_up;
        if (num_errors == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk_code(input logic [9:0] got, input logic [9:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %0t: value %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_mode(input logic [2:0] got, input logic [2:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %0t: mode %h expected %h", $time, got, exp);
        end
    endtask
    // bounded wait for the host to go idle
    task automatic wait_rdy;
        int n;
        @(negedge clk);
        for (n = 0; n < 2000 && ready !== 1'b1; n++) @(negedge clk);
        if (ready !== 1'b1) begin
            num_errors++;
            $display("Error %0t: host never became ready", $time);
            wrap_up();
        end
    endtask
    // power-on state of the model
    function automatic void clr;
        {reg_a, reg_b, exp_a, exp_b, exp_done} = '0;
        exp_pd = 1'b0;
        exp_term = 2'h0;
    endfunction
    // predicted effect of one complete frame
    function automatic void apply(input logic [15:0] f);
        logic [9:0] c;
        c = f[11:2];
        exp_done = exp_done + 10'h001;
        if (f[13:12] == ddsip_pkg::OP_POWER_DOWN) begin
            exp_pd = 1'b1;
            exp_term = f[14] ? ddsip_pkg::TERM_2K5 : ddsip_pkg::TERM_HIZ;
            return;
        end
        if (f[13:12] == ddsip_pkg::OP_BOTH_UPD) reg_a = c;
        if (f[13:12] == ddsip_pkg::OP_BOTH_UPD) reg_b = c;
        else if (f[14]) reg_b = c;
        else reg_a = c;
        if (f[13:12] == ddsip_pkg::OP_WRITE) return; // no update, no wake
        exp_a = reg_a;
        exp_b = reg_b;
        exp_pd = 1'b0;
    endfunction
    task automatic expect_all;
        chk_code(code_a, exp_a);
        chk_code(code_b, exp_b);
        chk_code(done_cnt, exp_done);
        chk_mode({powered_down, termination & {2{powered_down}}},
            {exp_pd, exp_term & {2{exp_pd}}});
    endtask
    // one request; ab above zero aborts that many cycles in
    task automatic send(input logic [15:0] f, input int ab);
        wait_rdy();
        @(posedge clk);
        req <= 1'b1;
        frame <= f;
        @(posedge clk);
        req <= 1'b0;
        repeat (ab) @(posedge clk);
        abort <= (ab > 0);
        wait_rdy();
        @(posedge clk);
        abort <= 1'b0;
        repeat (6) @(negedge clk);
        if (ab == 0) apply(f);
        expect_all();
    endtask
    initial begin
        void'($urandom(32'h2E02));
        clr();
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        expect_all();
        foreach (corners[i]) send(corners[i], 0);
        send(16'h2000, 50);
        for (int i = 0; i < 40; i++) begin
            int ab;
            ab = ($urandom % 4 == 0) ? 10 + int'($urandom % 90) : 0;
            send(16'($urandom), ab);
        end
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        clr();
        @(negedge clk);
        expect_all();
        send(16'h1FFC, 0);
        wrap_up();
    end
endmodule
`default_nettype wire
